// ==== hdl/psw_pkg.sv ====
// Constants for the protection setup serial word block
package psw_pkg;
    localparam int unsigned WORD_W        = 16;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam int unsigned SEL_LSB       = 0;
    localparam int unsigned SEL_W         = 4;
    localparam int unsigned MASK_CONV_BIT = 5;
    localparam int unsigned MASK_OC_BIT   = 6;
    localparam int unsigned MASK_OT_BIT   = 7;
    localparam int unsigned RMASK_C_BIT   = 8;
    localparam int unsigned RMASK_B_BIT   = 9;
    localparam int unsigned RMASK_A_BIT   = 10;
    localparam int unsigned EARLY_LSB     = 11;
    localparam int unsigned EARLY_W       = 2;
    localparam int unsigned WDOG_BIT      = 14;
    localparam int unsigned NUM_CONV      = 3;
    // Monitor selector codes
    localparam logic [3:0] SEL_CONV_A     = 4'h0;
    localparam logic [3:0] SEL_CONV_B     = 4'h1;
    localparam logic [3:0] SEL_CONV_C     = 4'h2;
    localparam logic [3:0] SEL_VOLT_HIGH  = 4'h4;
    localparam logic [3:0] SEL_VOLT_LOW   = 4'h5;
    localparam logic [3:0] SEL_OVERCUR    = 4'h6;
    localparam logic [3:0] SEL_OVERTEMP   = 4'h7;
    localparam logic [3:0] SEL_FILT_MAX   = 4'h7;
    // Early temperature warning levels
    localparam logic [1:0] EARLY_MINUS20  = 2'h0;
    localparam logic [1:0] EARLY_MINUS30  = 2'h1;
    localparam logic [1:0] EARLY_MINUS40  = 2'h2;
    localparam logic [1:0] EARLY_ANALOG   = 2'h3;
    // Watchdog window: converter osc between motor/64 and motor/2
    localparam int unsigned WDOG_DIV_LO   = 64;
    localparam int unsigned WDOG_DIV_HI   = 2;
    localparam int unsigned WDOG_CNT_W    = 8;
endpackage : psw_pkg

// ==== hdl/psw_sync.sv ====
// Two-flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module psw_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : psw_sync

// ==== hdl/psw_top.sv ====
// Protection setup serial word receiver with fault monitor and reset masking
// Contract
// - Serial port takes 16-bit words; pin combination picks the word kind.
// - Sleep low, strobe with data high is protection word, low is motor setup.
// - Protection word stored only with sleep low and data high at strobe.
// - Protection word configures protection and picks monitor output signal.
// - Bits 3..0 select the shutdown signal shown on the monitor pin.
// - Bits 5,6,7 disable converter fault, overcurrent, overtemp shutdown.
// - Bits 8,9,10 mask reset output for converters C, B, A.
// - Masked converter shutdown leaves other converters running.
// - Masked shut-down converter restarts on sleep rising edge.
// - Bits 12..11 pick early warning threshold: -20,-30,-40, analog.
// - Bit 14 enables oscillator watchdog; all bits reset to zero.
// - Warning and monitor outputs are open drain, pull low when asserted.
// - Power-on reset clears the protection word.
// - Selector codes choose converter A/B/C, high, low, overcurrent, overtemp.
// - Watchdog shuts down if converter osc outside motor/64..motor/2.
`timescale 1ns/10ps
module psw_top (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Serial pins from host
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    input  wire logic       ser_strobe,
    input  wire logic       sleep,
    // Fault sources from analog section
    input  wire logic [2:0] conv_volt_high,
    input  wire logic [2:0] conv_volt_low,
    input  wire logic       motor_overcurrent,
    input  wire logic       overtemp,
    input  wire logic [2:0] temp_below,
    // Oscillator ticks
    input  wire logic       osc_motor,
    input  wire logic       osc_conv,
    // Configuration and shutdown outputs
    output logic [15:0]     protection_setup_word,
    output logic [15:0]     shift_word,
    output logic            motor_setup_load,
    output logic [2:0]      conv_run,
    output logic            chip_shutdown,
    output logic            early_analog_mode,
    // Open-drain pins
    output logic            fault_monitor_out,
    output logic            fault_monitor_oe,
    output logic            temperature_warning_out,
    output logic            temperature_warning_oe,
    output logic            external_reset_out,
    output logic            external_reset_oe
);
    logic [5:0] pins_s;
    logic [5:0] pins_q;
    logic       sck_s, sdat_s, stb_s, slp_s, om_s, oc_s;

    psw_sync #(.WIDTH(6)) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .async_in({osc_conv, osc_motor, sleep, ser_strobe, ser_data, ser_clk}),
        .sync_out(pins_s)
    );
    assign {oc_s, om_s, slp_s, stb_s, sdat_s, sck_s} = pins_s;

    // Edge detection on synchronised pins only
    logic sck_rise, stb_rise, slp_rise, om_rise, oc_rise;
    assign sck_rise = sck_s & ~pins_q[0];
    assign stb_rise = stb_s & ~pins_q[2];
    assign slp_rise = slp_s & ~pins_q[3];
    assign om_rise  = om_s  & ~pins_q[4];
    assign oc_rise  = oc_s  & ~pins_q[5];

    // Serial word path
    logic [15:0] next_shift_word, next_prot;
    logic        next_motor_load;

    always_comb begin
        next_shift_word = shift_word;
        next_prot       = protection_setup_word;
        next_motor_load = 1'b0;
        if (sck_rise) begin
            next_shift_word = {shift_word[14:0], sdat_s};
        end
        if (stb_rise && !slp_s) begin
            if (sdat_s) begin
                next_prot = shift_word;
            end else begin
                next_motor_load = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q                <= '0;
            shift_word            <= '0;
            protection_setup_word <= psw_pkg::WORD_RESET;
            motor_setup_load      <= 1'b0;
        end else begin
            pins_q                <= pins_s;
            shift_word            <= next_shift_word;
            protection_setup_word <= next_prot;
            motor_setup_load      <= next_motor_load;
        end
    end

    // Field decode
    logic [3:0] sel;
    logic [1:0] early_sel;
    logic       mask_conv, mask_oc, mask_ot, wdog_en;
    logic [2:0] rmask;
    assign sel       = protection_setup_word[psw_pkg::SEL_LSB +: psw_pkg::SEL_W];
    assign early_sel = protection_setup_word[psw_pkg::EARLY_LSB +: psw_pkg::EARLY_W];
    assign mask_conv = protection_setup_word[psw_pkg::MASK_CONV_BIT];
    assign mask_oc   = protection_setup_word[psw_pkg::MASK_OC_BIT];
    assign mask_ot   = protection_setup_word[psw_pkg::MASK_OT_BIT];
    assign wdog_en   = protection_setup_word[psw_pkg::WDOG_BIT];
    // Index 0 is channel A, 2 is channel C
    assign rmask     = {protection_setup_word[psw_pkg::RMASK_C_BIT],
                        protection_setup_word[psw_pkg::RMASK_B_BIT],
                        protection_setup_word[psw_pkg::RMASK_A_BIT]};

    // Oscillator watchdog: count converter ticks per 64 motor ticks
    logic [psw_pkg::WDOG_CNT_W-1:0] om_cnt, next_om_cnt, oc_cnt, next_oc_cnt, oc_inc;
    logic                           wdog_trip, next_wdog_trip;
    localparam logic [7:0] WIN_LEN = 8'(psw_pkg::WDOG_DIV_LO - 1);
    localparam logic [7:0] WIN_MAX = 8'(psw_pkg::WDOG_DIV_LO / psw_pkg::WDOG_DIV_HI);
    // Saturates so a runaway converter cannot wrap back into the window
    assign oc_inc = (oc_rise && oc_cnt != 8'hFF) ? oc_cnt + 8'h01 : oc_cnt;

    always_comb begin
        next_om_cnt    = om_cnt;
        next_oc_cnt    = oc_cnt;
        next_wdog_trip = wdog_trip;
        if (!wdog_en) begin
            next_om_cnt    = '0;
            next_oc_cnt    = '0;
            next_wdog_trip = 1'b0;
        end else begin
            next_oc_cnt = oc_inc;
            if (om_rise) begin
                if (om_cnt == WIN_LEN) begin
                    next_om_cnt = '0;
                    next_oc_cnt = '0;
                    // Judge the closed window on its own count, this cycle's tick included
                    if (oc_inc < 8'h01 || oc_inc > WIN_MAX) begin
                        next_wdog_trip = 1'b1;
                    end
                end else begin
                    next_om_cnt = om_cnt + 8'h01;
                end
            end
            // Converter running far ahead trips without waiting for the window
            if (oc_cnt > WIN_MAX) begin
                next_wdog_trip = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            om_cnt    <= '0;
            oc_cnt    <= '0;
            wdog_trip <= 1'b0;
        end else begin
            om_cnt    <= next_om_cnt;
            oc_cnt    <= next_oc_cnt;
            wdog_trip <= next_wdog_trip;
        end
    end

    // Converter shutdown latches, per channel
    logic [2:0] conv_fault, conv_down, next_conv_down;
    logic       reset_req;
    assign conv_fault = (conv_volt_high | conv_volt_low) & {3{~mask_conv}};

    for (genvar ch = 0; ch < 3; ch++) begin : g_conv
        always_comb begin
            next_conv_down[ch] = conv_down[ch];
            // Set wins over the sleep-rise release
            if (conv_fault[ch]) begin
                next_conv_down[ch] = 1'b1;
            end else if (slp_rise) begin
                next_conv_down[ch] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_down <= '0;
        end else begin
            conv_down <= next_conv_down;
        end
    end

    // Unmasked converter down pulls reset and stops all; masked stops only itself
    assign reset_req     = |(conv_down & ~rmask);
    assign chip_shutdown = (motor_overcurrent & ~mask_oc) | (overtemp & ~mask_ot)
                         | wdog_trip;
    assign conv_run      = (reset_req || chip_shutdown) ? 3'h0 : ~conv_down;

    // Monitor selection
    logic mon_sel_val;
    always_comb begin
        unique case (sel)
            psw_pkg::SEL_CONV_A:    mon_sel_val = conv_down[0];
            psw_pkg::SEL_CONV_B:    mon_sel_val = conv_down[1];
            psw_pkg::SEL_CONV_C:    mon_sel_val = conv_down[2];
            psw_pkg::SEL_VOLT_HIGH: mon_sel_val = |conv_volt_high;
            psw_pkg::SEL_VOLT_LOW:  mon_sel_val = |conv_volt_low;
            psw_pkg::SEL_OVERCUR:   mon_sel_val = motor_overcurrent;
            psw_pkg::SEL_OVERTEMP:  mon_sel_val = overtemp;
            default:                mon_sel_val = 1'b0;
        endcase
    end

    // Registered open-drain drives: output always low, enable asserts
    logic mon_q, warn_q, rst_q, next_warn;
    always_comb begin
        unique case (early_sel)
            psw_pkg::EARLY_MINUS20: next_warn = temp_below[0];
            psw_pkg::EARLY_MINUS30: next_warn = temp_below[1];
            psw_pkg::EARLY_MINUS40: next_warn = temp_below[2];
            psw_pkg::EARLY_ANALOG:  next_warn = 1'b0;
        endcase
    end
    assign early_analog_mode = (early_sel == psw_pkg::EARLY_ANALOG);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_q  <= 1'b0;
            warn_q <= 1'b0;
            rst_q  <= 1'b0;
        end else begin
            mon_q  <= mon_sel_val;
            warn_q <= next_warn;
            rst_q  <= reset_req;
        end
    end

    assign fault_monitor_out       = 1'b0;
    assign fault_monitor_oe        = mon_q;
    assign temperature_warning_out = 1'b0;
    assign temperature_warning_oe  = warn_q;
    assign external_reset_out      = 1'b0;
    assign external_reset_oe       = rst_q;

    AST_PROT_LOAD: assert property (
        @(posedge clk) disable iff (!rst_n)
        stb_rise && !slp_s && sdat_s |=> protection_setup_word == $past(shift_word))
        else $error("protection word not loaded on strobe");
    AST_PROT_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(stb_rise && !slp_s && sdat_s) |=> $stable(protection_setup_word))
        else $error("protection word changed without strobe");
    AST_SHIFT: assert property (
        @(posedge clk) disable iff (!rst_n)
        sck_rise |=> shift_word[0] == $past(sdat_s))
        else $error("serial bit not shifted");
    AST_RMASK: assert property (
        @(posedge clk) disable iff (!rst_n)
        |conv_down && (conv_down & ~rmask) == 3'h0 |=> !external_reset_oe)
        else $error("masked channel asserted reset");
    AST_KEEP_RUN: assert property (
        @(posedge clk) disable iff (!rst_n)
        !reset_req && !chip_shutdown && conv_down[0] |-> conv_run[2:1] == ~conv_down[2:1])
        else $error("other converters stopped");
    AST_RESTART: assert property (
        @(posedge clk) disable iff (!rst_n)
        slp_rise && conv_fault == 3'h0 |=> conv_down == 3'h0)
        else $error("converter not restarted on sleep rise");
    AST_MON: assert property (
        @(posedge clk) disable iff (!rst_n)
        sel == psw_pkg::SEL_OVERTEMP ##1 $stable(overtemp) |-> fault_monitor_oe == $past(overtemp))
        else $error("monitor output wrong");
    AST_OT_MASK: assert property (
        @(posedge clk) disable iff (!rst_n)
        mask_ot && !motor_overcurrent && !wdog_trip |-> !chip_shutdown)
        else $error("masked overtemp shut down");
    AST_WDOG_OFF: assert property (
        @(posedge clk) disable iff (!rst_n)
        !wdog_en |=> !wdog_trip)
        else $error("watchdog tripped while off");

    COV_PROT: cover property (@(posedge clk) disable iff (!rst_n)
        stb_rise && !slp_s && sdat_s);
    COV_MOTOR: cover property (@(posedge clk) disable iff (!rst_n) motor_setup_load);
    COV_MASKED: cover property (@(posedge clk) disable iff (!rst_n)
        |conv_down && !reset_req);
    COV_WDOG: cover property (@(posedge clk) disable iff (!rst_n) wdog_trip);
endmodule : psw_top

// ==== dv/psw_host.sv ====
// Host model that shifts setup words into the serial pins
`timescale 1ns/10ps
module psw_host (
    // Clock used only to pace the pins
    input  wire logic clk,
    // Serial pins
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_strobe,
    output logic      sleep
);
    initial begin
        ser_clk    = 1'b0;
        ser_data   = 1'b0;
        ser_strobe = 1'b0;
        sleep      = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask : hold
    task automatic set_sleep(input logic v);
        sleep = v;
    endtask : set_sleep
    // Link clock idles low between frames, 400 ns period inside them
    task automatic send(input logic [15:0] w, input logic kind);
        logic [15:0] v;
        v = w & ~16'hA010;
        for (int i = 15; i >= 0; i--) begin
            ser_data = v[i];
            hold(4);
            ser_clk = 1'b1;
            hold(4);
            ser_clk = 1'b0;
        end
        ser_data = kind;
        hold(4);
        ser_strobe = 1'b1;
        hold(4);
        ser_strobe = 1'b0;
        hold(4);
        // Data no longer meaningful; do not leave the last value there
        ser_data = ~kind;
    endtask : send
endmodule : psw_host

// ==== dv/tb_top.sv ====
// Self-checking bench for the protection setup word receiver
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [15:0] word;
        logic        oc;
        logic        ot;
        logic [2:0]  tb3;
        logic [3:0]  exp;
    } psw_row_t;
    logic        clk, rst_n, ser_clk, ser_data, ser_strobe, sleep, oc, ot;
    logic        osc_m, osc_c, osc_on, ml, chip_sd, analog;
    logic        mon_out, mon_oe, warn_out, warn_oe, rst_out, rst_oe;
    logic [2:0]  vh, vl, tb3, conv_run;
    logic [15:0] word, shift_word;
    int          fail_count, total_checks, cycles, ml_cnt, n;
    // Expected bits: monitor, warning, shutdown, analog
    psw_row_t rows [11] = '{
        '{16'h0006, 1'h1, 1'h0, 3'h0, 4'hA}, '{16'h0043, 1'h1, 1'h0, 3'h0, 4'h0},
        '{16'h0007, 1'h0, 1'h1, 3'h0, 4'hA}, '{16'h0083, 1'h0, 1'h1, 3'h0, 4'h0},
        '{16'h0003, 1'h0, 1'h0, 3'h1, 4'h4}, '{16'h0803, 1'h0, 1'h0, 3'h1, 4'h0},
        '{16'h0803, 1'h0, 1'h0, 3'h2, 4'h4}, '{16'h1003, 1'h0, 1'h0, 3'h4, 4'h4},
        '{16'h1003, 1'h0, 1'h0, 3'h3, 4'h0}, '{16'h1803, 1'h0, 1'h0, 3'h7, 4'h1},
        '{16'h0008, 1'h1, 1'h0, 3'h0, 4'h2}};
    psw_top u_dut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_strobe(ser_strobe), .sleep(sleep), .conv_volt_high(vh), .conv_volt_low(vl),
        .motor_overcurrent(oc), .overtemp(ot), .temp_below(tb3), .osc_motor(osc_m),
        .osc_conv(osc_c), .protection_setup_word(word), .shift_word(shift_word),
        .motor_setup_load(ml), .conv_run(conv_run), .chip_shutdown(chip_sd),
        .early_analog_mode(analog), .fault_monitor_out(mon_out), .fault_monitor_oe(mon_oe),
        .temperature_warning_out(warn_out), .temperature_warning_oe(warn_oe),
        .external_reset_out(rst_out), .external_reset_oe(rst_oe));
    psw_host u_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_strobe(ser_strobe), .sleep(sleep));
    always #25 clk = ~clk;
    // Converter oscillator runs at one eighth of the motor one while enabled
    always begin
        repeat (4) @(negedge clk);
        osc_m = ~osc_m;
    end
    always begin
        repeat (32) @(negedge clk);
        if (osc_on) osc_c = ~osc_c;
    end
    // Counted at the falling edge, where the one-cycle pulse stands settled
    always @(negedge clk) begin
        cycles++;
        if (ml === 1'b1) ml_cnt++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_n(input int k);
        repeat (k) @(negedge clk);
    endtask : wait_n
    task automatic wr(input logic [15:0] w, input logic kind);
        u_host.send(w, kind);
        wait_n(5);
    endtask : wr
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        {clk, rst_n, oc, ot, osc_m, osc_c, vh, vl, tb3} = '0;
        osc_on = 1'b1;
        wait_n(12);
        rst_n = 1'b1;
        wait_n(3);
        chk("reset word", 16'h0000, word);
        chk("reset run", 16'h0007, 16'(conv_run));
        chk("reset oe", 16'h0000, 16'({mon_oe, warn_oe, rst_oe}));
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].word, 1'b1);
            {oc, ot, tb3} = {rows[i].oc, rows[i].ot, rows[i].tb3};
            wait_n(10);
            chk("word", rows[i].word, word);
            chk("shift", rows[i].word, shift_word);
            chk("monitor", 16'(rows[i].exp[3]), 16'(mon_oe));
            chk("warning", 16'(rows[i].exp[2]), 16'(warn_oe));
            chk("shutdown", 16'(rows[i].exp[1]), 16'(chip_sd));
            chk("analog", 16'(rows[i].exp[0]), 16'(analog));
            chk("od level", 16'h0000, 16'({mon_out, warn_out, rst_out}));
            {oc, ot, tb3} = '0;
            wait_n(4);
            $display("row %0d done", i);
        end
        n = ml_cnt;
        wr(16'h0123, 1'b0);
        chk("motor setup", 16'h0008, word);
        chk("setup pulses", 16'(n + 1), 16'(ml_cnt));
        u_host.set_sleep(1'b1);
        wr(16'h0123, 1'b1);
        u_host.set_sleep(1'b0);
        chk("sleep high", 16'h0008, word);
        chk("sleep pulses", 16'(n + 1), 16'(ml_cnt));
        $display("strobe kind test done");
        wr(16'h0400, 1'b1);
        vl = 3'h1;
        wait_n(10);
        chk("mask mon", 16'h0001, 16'(mon_oe));
        chk("mask rst", 16'h0000, 16'(rst_oe));
        chk("mask run", 16'h0006, 16'(conv_run));
        vl = 3'h0;
        wait_n(10);
        chk("latched run", 16'h0006, 16'(conv_run));
        u_host.set_sleep(1'b1);
        wait_n(6);
        chk("restart run", 16'h0007, 16'(conv_run));
        u_host.set_sleep(1'b0);
        wr(16'h0024, 1'b1);
        vh = 3'h4;
        wait_n(10);
        chk("vmask rst", 16'h0000, 16'({rst_oe, ~conv_run}));
        chk("high mon", 16'h0001, 16'(mon_oe));
        vh = 3'h0;
        wr(16'h0405, 1'b1);
        vl = 3'h2;
        wait_n(10);
        chk("low mon", 16'h0001, 16'(mon_oe));
        chk("unmasked rst", 16'h0001, 16'(rst_oe));
        chk("unmasked run", 16'h0000, 16'(conv_run));
        vl = 3'h0;
        rst_n = 1'b0;
        wait_n(2);
        rst_n = 1'b1;
        wait_n(3);
        chk("por word", 16'h0000, word);
        chk("por state", 16'h0007, 16'({rst_oe, conv_run}));
        $display("converter test done");
        wr(16'h4003, 1'b1);
        wait_n(600);
        chk("wdog ok", 16'h0000, 16'(chip_sd));
        osc_on = 1'b0;
        for (int k = 0; k < 1200 && chip_sd !== 1'b1; k++) @(negedge clk);
        chk("wdog trip", 16'h0001, 16'(chip_sd));
        wr(16'h0003, 1'b1);
        wait_n(4);
        chk("wdog off", 16'h0000, 16'(chip_sd));
        $display("watchdog test done");
        tally_and_finish();
    end
endmodule : tb_top
